// ### pkg/acr_pkg.sv
// Purpose: constants and carrier types for the audio main control register block
// Assumes: 32-bit AHB-Lite register access, single clock hclk
// Notes: all offsets are byte addresses on the system bus
package acr_pkg;

  // register map
  localparam logic [31:0] ACR_MAIN_CONTROL_ADDR = 32'hfff09000;
  localparam logic [31:0] ACR_INT_STATUS_ADDR = 32'hfff09080;
  localparam logic [31:0] ACR_INT_MASK_ADDR = 32'hfff09084;

  // audio_main_control field positions
  localparam int ACR_REC_FLAG_BIT = 12;
  localparam int ACR_PLAY_FLAG_BIT = 11;
  localparam int ACR_PIN_SEL_BIT = 8;
  localparam int ACR_FIFO_THRESHOLD_SELECT_BIT = 7;
  localparam int ACR_I2S_EN_BIT = 1;
  localparam int ACR_ACLINK_EN_BIT = 2;

  // reset value and access masks
  localparam logic [31:0] ACR_MAIN_CONTROL_RESET = 32'h00000000;
  localparam logic [31:0] ACR_MAIN_CONTROL_RW_MASK = 32'h00000186;
  localparam logic [31:0] ACR_MAIN_CONTROL_W1C_MASK = 32'h00001800;

  // interrupt status and mask layout
  localparam int ACR_INT_N = 2;
  localparam int ACR_INT_REC_BIT = 0;
  localparam int ACR_INT_PLAY_BIT = 1;
  localparam logic [ACR_INT_N-1:0] ACR_INT_RESET = 2'h0;

  // fifo thresholds in entries
  localparam logic [3:0] ACR_FIFO_THRESHOLD_SELECT_EIGHT = 4'h8;
  localparam logic [3:0] ACR_FIFO_THRESHOLD_SELECT_FOUR = 4'h4;

  // ahb-lite codes
  localparam logic [1:0] ACR_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] ACR_HTRANS_SEQ = 2'h3;
  localparam logic [2:0] ACR_HSIZE_WORD = 3'h2;

  typedef enum logic [2:0] {
    ACR_BUS_IDLE = 3'h1,
    ACR_BUS_WRITE = 3'h2,
    ACR_BUS_READ = 3'h4
  } acr_bus_state_t;

  // dma pointer set of one direction
  typedef struct packed {
    logic [31:0] base_addr;
    logic [31:0] end_addr;
    logic [31:0] cur_addr;
    logic step;
  } acr_dma_addr_t;

  // configuration driven to the audio engines
  typedef struct packed {
    logic pins_to_aclink;
    logic [3:0] fifo_threshold;
    logic i2s_enable;
    logic aclink_enable;
  } acr_cfg_t;

endpackage

// ### design/acr_addr_watch.sv
// Purpose: flags when a dma current address reaches the buffer middle or end
// Assumes: step pulses once per new current address
// Notes: hit is a registered one-cycle pulse
`timescale 1ns/10ps
module acr_addr_watch #(
  parameter int ADDR_W = 32
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire acr_pkg::acr_dma_addr_t dma,
  input wire logic armed,
  output logic hit
);

  typedef struct packed {
    logic hit;
  } acr_watch_state_t;

  acr_watch_state_t state_reg;
  acr_watch_state_t state_next;
  logic [ADDR_W-1:0] mid_addr;
  logic [ADDR_W-1:0] span;

  // refuse compare widths the address fields cannot serve
  if (ADDR_W < 2 || ADDR_W > 32) begin : g_bad_width
    $error("acr_addr_watch: ADDR_W must be 2 to 32");
  end

  always_comb begin
    span = dma.end_addr[ADDR_W-1:0] - dma.base_addr[ADDR_W-1:0];
    mid_addr = ((span - {{(ADDR_W-1){1'b0}}, 1'b1}) >> 1) + dma.base_addr[ADDR_W-1:0];
    state_next = state_reg;
    state_next.hit = armed && dma.step &&
                     ((dma.cur_addr[ADDR_W-1:0] == mid_addr) ||
                      (dma.cur_addr[ADDR_W-1:0] == dma.end_addr[ADDR_W-1:0]));
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign hit = state_reg.hit;

endmodule

// ### design/acr_sticky_irq.sv
// Purpose: sticky interrupt status with write-one-to-clear, mask and level output
// Assumes: events are one-cycle pulses
// Notes: a new event wins over a clear in the same cycle
`timescale 1ns/10ps
module acr_sticky_irq #(
  parameter int N = 2
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [N-1:0] event_in,
  input wire logic status_wr,
  input wire logic mask_wr,
  input wire logic [N-1:0] wdata,
  output logic [N-1:0] status,
  output logic [N-1:0] mask,
  output logic irq
);

  typedef struct packed {
    logic [N-1:0] status;
    logic [N-1:0] mask;
    logic irq;
  } acr_irq_state_t;

  acr_irq_state_t state_reg;
  acr_irq_state_t state_next;

  // refuse status widths beyond one bus word
  if (N < 1 || N > 32) begin : g_bad_width
    $error("acr_sticky_irq: N must be 1 to 32");
  end

  always_comb begin
    state_next = state_reg;
    if (status_wr) begin
      state_next.status = state_reg.status & ~wdata;
    end
    state_next.status = state_next.status | event_in;
    if (mask_wr) begin
      state_next.mask = wdata;
    end
    state_next.irq = |(state_next.status & state_next.mask);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign status = state_reg.status;
  assign mask = state_reg.mask;
  assign irq = state_reg.irq;

endmodule

// ### design/acr_main_control.sv
// Purpose: audio main control register with dma interrupt flags on ahb-lite
// Assumes: single word transfers, dma address sets supplied by the dma engines
// Notes: writes take no wait state, reads take one
// Behaviour
// [R01] While recording, the record dma flag sets when the current address hits the middle or end.
// [R02] Writing one to the record dma flag clears it to zero.
// [R03] Each interrupt request line is the inverse of its dma flag, low while the flag is set.
// [R04] The playback dma flag sets when the current address hits ((end-base)-1)/2+base or the end.
// [R05] Writing one to the playback dma flag clears it to zero.
// [R06] Pin function select zero routes the shared pins to i2s, one routes them to ac-link.
// [R07] Fifo threshold select zero gives eight entries, one gives four.
// [R08] Enable field bit zero enables i2s and bit one enables ac-link.
// [R09] Reset clears the whole control register, so interfaces are off, pins i2s, threshold eight.
// [R10] Writing zero to a dma flag does nothing, and reserved bits read zero and ignore writes.
//
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/10ps
module acr_main_control #(
  parameter int ADDR_W = 32
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic rec_active,
  input wire acr_pkg::acr_dma_addr_t rec_dma,
  input wire acr_pkg::acr_dma_addr_t play_dma,
  output acr_pkg::acr_cfg_t cfg,
  output logic rec_irq_n,
  output logic play_irq_n,
  output logic irq
);

  typedef struct packed {
    acr_pkg::acr_bus_state_t bus_state;
    logic [31:0] addr;
    logic hreadyout;
    logic [31:0] hrdata;
    logic [31:0] ctrl;
    acr_pkg::acr_cfg_t cfg;
    logic rec_irq_n;
    logic play_irq_n;
  } acr_main_state_t;

  acr_main_state_t state_reg;
  acr_main_state_t state_next;

  acr_pkg::acr_dma_addr_t dma_set [2];
  logic [1:0] dma_armed;
  logic [1:0] dma_hit;
  logic [acr_pkg::ACR_INT_N-1:0] int_status;
  logic [acr_pkg::ACR_INT_N-1:0] int_mask;
  logic [acr_pkg::ACR_INT_N-1:0] int_event;
  logic int_status_wr;
  logic int_mask_wr;
  logic irq_level;
  logic bus_take;
  logic wr_phase;
  logic [31:0] w1c_clear;
  logic [31:0] flag_set;

  // refuse compare widths the address fields cannot serve
  if (ADDR_W < 2 || ADDR_W > 32) begin : g_bad_width
    $error("acr_main_control: ADDR_W must be 2 to 32");
  end

  function automatic logic is_addr(input logic [31:0] a, input logic [31:0] ref_addr);
    is_addr = (a[31:2] == ref_addr[31:2]);
  endfunction

  // record direction is watched only while recording
  assign dma_set[0] = rec_dma;
  assign dma_set[1] = play_dma;
  assign dma_armed[0] = rec_active; // [R01]
  assign dma_armed[1] = 1'b1; // [R04]

  generate
    for (genvar g = 0; g < 2; g++) begin : g_watch
      acr_addr_watch #(
        .ADDR_W(ADDR_W)
      ) u_watch (
        .hclk(hclk),
        .hresetn(hresetn),
        .dma(dma_set[g]),
        .armed(dma_armed[g]),
        .hit(dma_hit[g])
      );
    end
  endgenerate

  // bus phase decode
  assign bus_take = hsel && hready &&
                    (htrans == acr_pkg::ACR_HTRANS_NONSEQ || htrans == acr_pkg::ACR_HTRANS_SEQ);
  assign wr_phase = (state_reg.bus_state == acr_pkg::ACR_BUS_WRITE);

  // write-one-to-clear of dma flags, zeros leave them alone
  always_comb begin
    w1c_clear = '0;
    if (wr_phase && is_addr(state_reg.addr, acr_pkg::ACR_MAIN_CONTROL_ADDR)) begin
      w1c_clear = hwdata & acr_pkg::ACR_MAIN_CONTROL_W1C_MASK; // [R02] [R05] [R10]
    end
  end

  always_comb begin
    flag_set = '0;
    flag_set[acr_pkg::ACR_REC_FLAG_BIT] = dma_hit[0]; // [R01]
    flag_set[acr_pkg::ACR_PLAY_FLAG_BIT] = dma_hit[1]; // [R04]
  end

  // flag set events feed the sticky interrupt status
  always_comb begin
    int_event = '0;
    int_event[acr_pkg::ACR_INT_REC_BIT] = dma_hit[0];
    int_event[acr_pkg::ACR_INT_PLAY_BIT] = dma_hit[1];
  end

  assign int_status_wr = wr_phase && is_addr(state_reg.addr, acr_pkg::ACR_INT_STATUS_ADDR);
  assign int_mask_wr = wr_phase && is_addr(state_reg.addr, acr_pkg::ACR_INT_MASK_ADDR);

  acr_sticky_irq #(
    .N(acr_pkg::ACR_INT_N)
  ) u_irq (
    .hclk(hclk),
    .hresetn(hresetn),
    .event_in(int_event),
    .status_wr(int_status_wr),
    .mask_wr(int_mask_wr),
    .wdata(hwdata[acr_pkg::ACR_INT_N-1:0]),
    .status(int_status),
    .mask(int_mask),
    .irq(irq_level)
  );

  always_comb begin
    state_next = state_reg;
    state_next.hreadyout = 1'b1;

    // control register update, set wins over clear
    if (wr_phase && is_addr(state_reg.addr, acr_pkg::ACR_MAIN_CONTROL_ADDR)) begin
      state_next.ctrl = (state_reg.ctrl & ~acr_pkg::ACR_MAIN_CONTROL_RW_MASK) |
                        (hwdata & acr_pkg::ACR_MAIN_CONTROL_RW_MASK); // [R10]
    end
    state_next.ctrl = (state_next.ctrl & ~w1c_clear) | flag_set; // [R02] [R05]
    state_next.ctrl = state_next.ctrl &
                      (acr_pkg::ACR_MAIN_CONTROL_RW_MASK |
                       acr_pkg::ACR_MAIN_CONTROL_W1C_MASK); // [R10]

    // bus state machine
    case (state_reg.bus_state)
      acr_pkg::ACR_BUS_READ: begin
        // wait cycle: read data is built from settled state
        state_next.hreadyout = 1'b1;
        if (is_addr(state_reg.addr, acr_pkg::ACR_MAIN_CONTROL_ADDR)) begin
          state_next.hrdata = state_reg.ctrl; // [R10]
        end else if (is_addr(state_reg.addr, acr_pkg::ACR_INT_STATUS_ADDR)) begin
          state_next.hrdata = {{(32-acr_pkg::ACR_INT_N){1'b0}}, int_status};
        end else if (is_addr(state_reg.addr, acr_pkg::ACR_INT_MASK_ADDR)) begin
          state_next.hrdata = {{(32-acr_pkg::ACR_INT_N){1'b0}}, int_mask};
        end else begin
          state_next.hrdata = '0;
        end
        state_next.bus_state = acr_pkg::ACR_BUS_IDLE;
      end
      default: begin
        state_next.bus_state = acr_pkg::ACR_BUS_IDLE;
        if (bus_take) begin
          state_next.addr = haddr;
          if (hwrite) begin
            state_next.bus_state = acr_pkg::ACR_BUS_WRITE;
          end else begin
            state_next.bus_state = acr_pkg::ACR_BUS_READ;
            state_next.hreadyout = 1'b0;
          end
        end
      end
    endcase

    // configuration outputs follow the next control value
    state_next.cfg.pins_to_aclink = state_next.ctrl[acr_pkg::ACR_PIN_SEL_BIT]; // [R06]
    state_next.cfg.fifo_threshold = state_next.ctrl[acr_pkg::ACR_FIFO_THRESHOLD_SELECT_BIT] ?
                                    acr_pkg::ACR_FIFO_THRESHOLD_SELECT_FOUR :
                                    acr_pkg::ACR_FIFO_THRESHOLD_SELECT_EIGHT; // [R07]
    state_next.cfg.i2s_enable = state_next.ctrl[acr_pkg::ACR_I2S_EN_BIT]; // [R08]
    state_next.cfg.aclink_enable = state_next.ctrl[acr_pkg::ACR_ACLINK_EN_BIT]; // [R08]
    state_next.rec_irq_n = ~state_next.ctrl[acr_pkg::ACR_REC_FLAG_BIT]; // [R03]
    state_next.play_irq_n = ~state_next.ctrl[acr_pkg::ACR_PLAY_FLAG_BIT]; // [R03]
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg.bus_state <= acr_pkg::ACR_BUS_IDLE;
      state_reg.addr <= '0;
      state_reg.hreadyout <= 1'b1;
      state_reg.hrdata <= '0;
      state_reg.ctrl <= acr_pkg::ACR_MAIN_CONTROL_RESET; // [R09]
      state_reg.cfg.pins_to_aclink <= 1'b0; // [R09]
      state_reg.cfg.fifo_threshold <= acr_pkg::ACR_FIFO_THRESHOLD_SELECT_EIGHT; // [R09]
      state_reg.cfg.i2s_enable <= 1'b0;
      state_reg.cfg.aclink_enable <= 1'b0;
      state_reg.rec_irq_n <= 1'b1;
      state_reg.play_irq_n <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign hreadyout = state_reg.hreadyout;
  assign hresp = 1'b0;
  assign hrdata = state_reg.hrdata;
  assign cfg = state_reg.cfg;
  assign rec_irq_n = state_reg.rec_irq_n;
  assign play_irq_n = state_reg.play_irq_n;
  assign irq = irq_level;

endmodule

// ### tb/acr_main_control_asserts.sv
// Purpose: port assertions for acr_main_control
// Assumes: one clock hclk, async active-low hresetn
// Notes: bound to the design below
`timescale 1ns/10ps
module acr_main_control_asserts #(
  parameter int ADDR_W = 32
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic rec_active,
  input wire acr_pkg::acr_dma_addr_t rec_dma,
  input wire acr_pkg::acr_dma_addr_t play_dma,
  input wire acr_pkg::acr_cfg_t cfg,
  input wire logic rec_irq_n,
  input wire logic play_irq_n,
  input wire logic irq
);
  logic [31:0] rmid;
  logic [31:0] pmid;
  assign rmid = ((rec_dma.end_addr - rec_dma.base_addr) - 32'h1) / 2 + rec_dma.base_addr;
  assign pmid = ((play_dma.end_addr - play_dma.base_addr) - 32'h1) / 2 + play_dma.base_addr;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_wr;
    hsel && hready && htrans[1] && hwrite && haddr == acr_pkg::ACR_MAIN_CONTROL_ADDR;
  endsequence
  sequence s_rd;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  a_rec_hit: assert property (
    rec_dma.step && rec_active &&
    (rec_dma.cur_addr == rec_dma.end_addr || rec_dma.cur_addr == rmid)
    |-> ##2 !rec_irq_n) else $error("record flag missed");
  a_rec_cause: assert property (
    $fell(rec_irq_n) |-> $past(rec_dma.step && rec_active, 2)) else $error("record flag early");
  a_play_hit: assert property (
    play_dma.step && (play_dma.cur_addr == play_dma.end_addr || play_dma.cur_addr == pmid)
    |-> ##2 !play_irq_n) else $error("playback flag missed");
  a_play_cause: assert property (
    $fell(play_irq_n) |-> $past(play_dma.step, 2)) else $error("playback flag early");
  a_rec_clear: assert property (
    s_wr ##0 !rec_dma.step ##1 hwdata[12] |=> rec_irq_n) else $error("record flag kept");
  a_play_clear: assert property (
    s_wr ##0 !play_dma.step ##1 hwdata[11] |=> play_irq_n) else $error("playback flag kept");
  a_cfg_write: assert property (
    s_wr ##1 1'b1 |=> cfg.pins_to_aclink == $past(hwdata[8]) && cfg.i2s_enable == $past(hwdata[1])
    && cfg.aclink_enable == $past(hwdata[2]) && cfg.fifo_threshold == ($past(hwdata[7]) ?
    acr_pkg::ACR_FIFO_THRESHOLD_SELECT_FOUR : acr_pkg::ACR_FIFO_THRESHOLD_SELECT_EIGHT)) else $error("config mismatch");
  a_resv_zero: assert property (
    s_rd ##0 haddr == acr_pkg::ACR_MAIN_CONTROL_ADDR ##1 !hreadyout ##1 hreadyout
    |-> (hrdata & 32'hffff_e679) == 32'h0) else $error("reserved bit set");
  a_read_wait: assert property (
    s_rd |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
endmodule
bind acr_main_control acr_main_control_asserts #(.ADDR_W(ADDR_W)) u_asserts (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .rec_active(rec_active), .rec_dma(rec_dma), .play_dma(play_dma),
  .cfg(cfg), .rec_irq_n(rec_irq_n), .play_irq_n(play_irq_n), .irq(irq));

// ### tb/acr_dma_model.sv
// Purpose: dma engine model stepping the current address
// Assumes: one new address every fourth cycle while run is high
// Notes: wraps to base after the end address
`timescale 1ns/10ps
module acr_dma_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic run,
  input wire logic [31:0] base,
  input wire logic [31:0] end_a,
  output acr_pkg::acr_dma_addr_t dma
);
  logic [1:0] gap_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dma <= '0;
      gap_reg <= 2'h0;
    end else begin
      gap_reg <= gap_reg + 2'h1;
      dma.base_addr <= base;
      dma.end_addr <= end_a;
      dma.step <= run && gap_reg == 2'h3;
      if (!run) begin
        dma.cur_addr <= base - 32'h1;
      end else if (gap_reg == 2'h3) begin
        dma.cur_addr <= (dma.cur_addr == end_a) ? base : dma.cur_addr + 32'h1;
      end
    end
  end
endmodule

// ### tb/acr_main_control_bench.sv
// Purpose: self-checking bench for acr_main_control
// Assumes: hready tied to hreadyout, dma models feed both watches
// Notes: expected values follow the field map
`timescale 1ns/10ps
module acr_main_control_bench;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic rec_active = 1'b0;
  logic rec_run = 1'b0;
  logic play_run = 1'b0;
  logic hreadyout, hresp, rec_irq_n, play_irq_n, irq;
  logic [31:0] hrdata;
  logic [31:0] q;
  acr_pkg::acr_dma_addr_t rec_dma, play_dma;
  acr_pkg::acr_cfg_t cfg;
  int fails = 0;
  int samples_checked = 0;
  int cyc = 0;
  localparam logic [31:0] CTRL = acr_pkg::ACR_MAIN_CONTROL_ADDR;
  always #2.5 hclk = ~hclk;
  acr_main_control uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(acr_pkg::ACR_HSIZE_WORD), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .rec_active(rec_active), .rec_dma(rec_dma), .play_dma(play_dma), .cfg(cfg),
    .rec_irq_n(rec_irq_n), .play_irq_n(play_irq_n), .irq(irq));
  acr_dma_model rec_src (.hclk(hclk), .hresetn(hresetn), .run(rec_run), .base(32'h2000),
    .end_a(32'h2003), .dma(rec_dma));
  acr_dma_model play_src (.hclk(hclk), .hresetn(hresetn), .run(play_run), .base(32'h1000),
    .end_a(32'h1010), .dma(play_dma));
  task end_sim;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= acr_pkg::ACR_HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    @(negedge hclk);
    while (hreadyout !== 1'b1) @(negedge hclk);
    @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(negedge hclk);
    while (hreadyout !== 1'b1) @(negedge hclk);
    q = hrdata;
    chk({31'h0, hresp}, 32'h0);
    @(posedge hclk);
  endtask
  task settle;
    repeat (2) @(negedge hclk);
  endtask
  task wait_low(input logic rec);
    int i;
    for (i = 0; i < 200 && (rec ? rec_irq_n : play_irq_n) !== 1'b0; i++) @(negedge hclk);
    chk({31'h0, (rec ? rec_irq_n : play_irq_n)}, 32'h0);
  endtask
  task wcfg(input logic [31:0] d, input logic [6:0] e);
    bus(1'b1, CTRL, d);
    settle;
    chk({25'h0, cfg}, {25'h0, e});
    bus(1'b0, CTRL, 32'h0);
    chk(q, d & 32'h186);
  endtask
  task t_reset;
    chk({25'h0, cfg}, 32'h20);
    chk({29'h0, rec_irq_n, play_irq_n, irq}, 32'h6);
    bus(1'b0, CTRL, 32'h0);
    chk(q, 32'h0);
  endtask
  task t_cfg;
    wcfg(32'hffff_ffff, 7'h53);
    wcfg(32'h0000_0002, 7'h22);
    wcfg(32'h0000_0004, 7'h21);
    wcfg(32'h0000_0180, 7'h50);
    bus(1'b0, 32'hfff0_9040, 32'h0);
    chk(q, 32'h0);
    wcfg(32'h0, 7'h20);
  endtask
  task t_play;
    @(posedge hclk);
    play_run <= 1'b1;
    wait_low(1'b0);
    chk(play_dma.cur_addr, 32'h1007);
    bus(1'b1, CTRL, 32'h800);
    settle;
    chk({31'h0, play_irq_n}, 32'h1);
    wait_low(1'b0);
    chk(play_dma.cur_addr, 32'h1010);
    @(posedge hclk);
    play_run <= 1'b0;
    bus(1'b1, CTRL, 32'h0);
    bus(1'b0, CTRL, 32'h0);
    chk(q, 32'h800);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, acr_pkg::ACR_INT_MASK_ADDR, 32'h2);
    settle;
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, acr_pkg::ACR_INT_STATUS_ADDR, 32'h2);
    settle;
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, CTRL, 32'h800);
    bus(1'b0, CTRL, 32'h0);
    chk(q, 32'h0);
  endtask
  task t_rec;
    @(posedge hclk);
    rec_run <= 1'b1;
    repeat (40) @(negedge hclk);
    chk({31'h0, rec_irq_n}, 32'h1);
    @(posedge hclk);
    rec_active <= 1'b1;
    wait_low(1'b1);
    bus(1'b0, CTRL, 32'h0);
    chk(q, 32'h1000);
    @(posedge hclk);
    rec_run <= 1'b0;
    bus(1'b1, CTRL, 32'h1000);
    settle;
    chk({31'h0, rec_irq_n}, 32'h1);
  endtask
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    t_reset;
    t_cfg;
    t_play;
    t_rec;
    end_sim;
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      end_sim;
    end
  end
endmodule
